// *** logic/csrc_pkg.sv ***
`default_nettype none
package csrc_pkg;
    // Register addresses on the serial control port.
    localparam logic [9:0] CSRC_ADDR_PLL_CONTROL = 10'h010;
    localparam logic [9:0] CSRC_ADDR_PREDIV_RATIO = 10'h1e0;
    localparam logic [9:0] CSRC_ADDR_SOURCE_SELECT = 10'h1e1;
    // Field positions.
    localparam int CSRC_POL_BIT = 7;
    localparam int CSRC_BYPASS_BIT = 0;
    localparam int CSRC_SRCSEL_BIT = 1;
    // Power-mode codes.
    localparam logic [1:0] CSRC_PWR_NORMAL = 2'h0;
    localparam logic [1:0] CSRC_PWR_ASYNC_PD = 2'h1;
    // Values after reset.
    localparam logic [7:0] CSRC_PLL_CONTROL_RST = 8'h01;
    localparam logic [7:0] CSRC_PREDIV_RATIO_RST = 8'h02;
    localparam logic [7:0] CSRC_SOURCE_SELECT_RST = 8'h00;
    // Pre-divider field codes; code n selects divide-by-(n+2).
    localparam logic [2:0] CSRC_DIV_CODE_MIN = 3'h0;
    localparam logic [2:0] CSRC_DIV_CODE_MAX = 3'h4;
    localparam logic [2:0] CSRC_DIV_RATIO_MIN = 3'h2;
endpackage : csrc_pkg
`default_nettype wire

// *** logic/csrc_ratio_map.sv ***
`default_nettype none
module csrc_ratio_map
    import csrc_pkg::*;
(
    // Field code in.
    input wire logic [2:0] code,
    // Ratio out.
    output logic [2:0] ratio,
    output logic supported
);
    always_comb begin
        supported = (code >= CSRC_DIV_CODE_MIN) && (code <= CSRC_DIV_CODE_MAX);
        // Unsupported codes fall back to the smallest ratio so the path never runs undivided.
        ratio = supported ? 3'(code + CSRC_DIV_RATIO_MIN) : CSRC_DIV_RATIO_MIN;
    end
endmodule : csrc_ratio_map
`default_nettype wire

// *** logic/csrc_top.sv ***
// Notes on behaviour
// - At reset the PLL is powered down and external clock passes the pre-divider.
// - Pre-divider ratio field bits 2:0 reset to the divide-by-4 code.
// - Pre-divider offers ratios 2 to 6; the divided path never divides below 2.
// - Source bit 1 low selects external clock; bit 0 low uses pre-divider; both reset low.
// - All three registers return to defaults on every reset.
// - PLL on with external clock selected powers down the oscillator, feeds prescaler.
// - PLL control bit 7 sets detector polarity: zero positive, one negative.
// - Power-mode code 00 puts the PLL into normal operation.
// - Source bit 0 set bypasses the pre-divider, feeding distribution directly.
`default_nettype none
module csrc_top
    import csrc_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Register write and read port from the serial control logic.
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RVALID,
    // Analog PLL controls.
    output logic PLL_POWER_ON,
    output logic [1:0] PLL_POWER_MODE,
    output logic PD_POLARITY_NEG,
    // Source routing controls.
    output logic SRC_OSC_SEL,
    output logic PREDIV_BYPASS,
    output logic [2:0] PREDIV_RATIO,
    output logic PREDIV_CODE_BAD,
    output logic OSC_POWER_ON,
    output logic EXT_TO_PRESCALER
);
    logic [7:0] pll_control_reg;
    logic [7:0] predivider_ratio_reg;
    logic [7:0] source_select_reg;
    logic [2:0] ratio_next;
    logic supported_next;
    logic pll_on_next;
    logic ext_sel_next;

    // Registers restore defaults on every reset, whatever was written before.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pll_control_reg <= CSRC_PLL_CONTROL_RST;
            predivider_ratio_reg <= CSRC_PREDIV_RATIO_RST;
            source_select_reg <= CSRC_SOURCE_SELECT_RST;
        end else if (WR_EN) begin
            if (ADDR == CSRC_ADDR_PLL_CONTROL) begin
                pll_control_reg <= WDATA;
            end
            if (ADDR == CSRC_ADDR_PREDIV_RATIO) begin
                predivider_ratio_reg <= WDATA;
            end
            if (ADDR == CSRC_ADDR_SOURCE_SELECT) begin
                source_select_reg <= WDATA;
            end
        end
    end

    // Read data answers one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
            RVALID <= 1'b0;
        end else begin
            RVALID <= RD_EN;
            if (RD_EN) begin
                unique case (ADDR)
                    CSRC_ADDR_PLL_CONTROL: RDATA <= pll_control_reg;
                    CSRC_ADDR_PREDIV_RATIO: RDATA <= predivider_ratio_reg;
                    CSRC_ADDR_SOURCE_SELECT: RDATA <= source_select_reg;
                    default: RDATA <= 8'h00;
                endcase
            end
        end
    end

    csrc_ratio_map u_map (
        .code(predivider_ratio_reg[2:0]),
        .ratio(ratio_next),
        .supported(supported_next)
    );

    assign pll_on_next = (pll_control_reg[1:0] == CSRC_PWR_NORMAL);
    assign ext_sel_next = !source_select_reg[CSRC_SRCSEL_BIT];

    // Outputs are registered so the analog controls never see decode glitches.
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PLL_POWER_ON <= 1'b0;
            PLL_POWER_MODE <= CSRC_PWR_ASYNC_PD;
            PD_POLARITY_NEG <= 1'b0;
            SRC_OSC_SEL <= 1'b0;
            PREDIV_BYPASS <= 1'b0;
            PREDIV_RATIO <= 3'(CSRC_PREDIV_RATIO_RST[2:0] + CSRC_DIV_RATIO_MIN);
            PREDIV_CODE_BAD <= 1'b0;
            OSC_POWER_ON <= 1'b0;
            EXT_TO_PRESCALER <= 1'b0;
        end else begin
            PLL_POWER_ON <= pll_on_next;
            PLL_POWER_MODE <= pll_control_reg[1:0];
            PD_POLARITY_NEG <= pll_control_reg[CSRC_POL_BIT];
            SRC_OSC_SEL <= !ext_sel_next;
            PREDIV_BYPASS <= source_select_reg[CSRC_BYPASS_BIT];
            PREDIV_RATIO <= ratio_next;
            PREDIV_CODE_BAD <= !supported_next;
            OSC_POWER_ON <= pll_on_next && !ext_sel_next;
            EXT_TO_PRESCALER <= pll_on_next && ext_sel_next;
        end
    end

    sequence s_write_src;
        WR_EN && ADDR == CSRC_ADDR_SOURCE_SELECT;
    endsequence

    a_reset_defaults: assert property (@(posedge REF_CLK) $rose(RSTN) |->
        pll_control_reg == CSRC_PLL_CONTROL_RST && source_select_reg == 8'h00)
        else $error("registers not at defaults after reset");
    a_div4_default: assert property (@(posedge REF_CLK) $rose(RSTN) |->
        predivider_ratio_reg[2:0] == 3'h2)
        else $error("pre-divider default is not divide-by-4");
    a_power_mode: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        pll_control_reg[1:0] == 2'h0 |=> PLL_POWER_ON)
        else $error("code 00 did not power the PLL");
    a_polarity_map: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        1'b1 |=> PD_POLARITY_NEG == $past(pll_control_reg[7]))
        else $error("polarity output mismatch");
    a_osc_off_ext: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        EXT_TO_PRESCALER |-> !OSC_POWER_ON && PLL_POWER_ON && !SRC_OSC_SEL)
        else $error("oscillator powered while external feeds prescaler");
    a_ratio_range: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        PREDIV_RATIO >= 3'h2 && PREDIV_RATIO <= 3'h6)
        else $error("pre-divider ratio out of range");
    a_bypass_write: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        s_write_src ##1 !(WR_EN && ADDR == CSRC_ADDR_SOURCE_SELECT) |=>
        PREDIV_BYPASS == $past(WDATA[0], 2))
        else $error("bypass output does not follow source bit 0");
    a_bad_code: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        predivider_ratio_reg[2:0] > 3'h4 |=> PREDIV_CODE_BAD && PREDIV_RATIO == 3'h2)
        else $error("unsupported code not flagged");
    a_ext_select: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !source_select_reg[1] |=> !SRC_OSC_SEL)
        else $error("external clock not selected with bit 1 low");
    a_osc_select: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        source_select_reg[CSRC_SRCSEL_BIT] |=> SRC_OSC_SEL)
        else $error("oscillator not selected with bit 1 high");
    a_divider_used: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !source_select_reg[CSRC_BYPASS_BIT] |=> !PREDIV_BYPASS)
        else $error("pre-divider bypassed with bit 0 low");
    a_ratio_map: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        predivider_ratio_reg[2:0] <= CSRC_DIV_CODE_MAX |=> !PREDIV_CODE_BAD
        && PREDIV_RATIO == 3'($past(predivider_ratio_reg[2:0]) + CSRC_DIV_RATIO_MIN))
        else $error("supported code gave the wrong ratio");

    // Any power mode other than normal keeps every PLL-dependent control off.
    a_pll_off: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        pll_control_reg[1:0] != CSRC_PWR_NORMAL |=> !PLL_POWER_ON && !OSC_POWER_ON
        && !EXT_TO_PRESCALER)
        else $error("PLL controls active outside normal mode");
    a_ext_feed: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        pll_control_reg[1:0] == CSRC_PWR_NORMAL && !source_select_reg[CSRC_SRCSEL_BIT]
        |=> EXT_TO_PRESCALER && !OSC_POWER_ON)
        else $error("external clock not fed to prescaler with PLL on");
    a_mode_copy: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        1'b1 |=> PLL_POWER_MODE == $past(pll_control_reg[1:0]))
        else $error("power-mode output does not follow the register");

    // The analog side must see distribution-only mode for two edges after reset.
    sequence s_reset_release;
        $rose(RSTN);
    endsequence

    a_reset_outputs: assert property (@(posedge REF_CLK) s_reset_release |->
        PLL_POWER_MODE == CSRC_PWR_ASYNC_PD && !PLL_POWER_ON && !SRC_OSC_SEL
        && !PREDIV_BYPASS && PREDIV_RATIO == 3'h4)
        else $error("outputs not in distribution-only mode at reset release");
    a_reset_settle: assert property (@(posedge REF_CLK) s_reset_release ##1 RSTN |->
        PLL_POWER_MODE == CSRC_PWR_ASYNC_PD && !PLL_POWER_ON && !SRC_OSC_SEL
        && !PREDIV_BYPASS && PREDIV_RATIO == 3'h4)
        else $error("outputs left distribution-only mode too early");

    // A read returns the register as it stood at the strobe, even if written then.
    sequence s_read_pll;
        RD_EN && ADDR == CSRC_ADDR_PLL_CONTROL;
    endsequence

    sequence s_read_prediv;
        RD_EN && ADDR == CSRC_ADDR_PREDIV_RATIO;
    endsequence

    sequence s_read_source;
        RD_EN && ADDR == CSRC_ADDR_SOURCE_SELECT;
    endsequence

    a_read_pll: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        s_read_pll |=> RVALID && RDATA == $past(pll_control_reg))
        else $error("control register read back wrong");
    a_read_prediv: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        s_read_prediv |=> RVALID && RDATA == $past(predivider_ratio_reg))
        else $error("pre-divider register read back wrong");
    a_read_source: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        s_read_source |=> RVALID && RDATA == $past(source_select_reg))
        else $error("source register read back wrong");
    a_read_pulse: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !RD_EN |=> !RVALID)
        else $error("read valid without a read strobe");

    // Registers hold unless a write hits their own address.
    a_hold_idle: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !WR_EN |=> $stable(pll_control_reg) && $stable(predivider_ratio_reg)
        && $stable(source_select_reg))
        else $error("register changed without a write");
    a_unmapped_write: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        WR_EN && ADDR != CSRC_ADDR_PLL_CONTROL && ADDR != CSRC_ADDR_PREDIV_RATIO
        && ADDR != CSRC_ADDR_SOURCE_SELECT |=> $stable(pll_control_reg)
        && $stable(predivider_ratio_reg) && $stable(source_select_reg))
        else $error("write to an unmapped address changed a register");
endmodule : csrc_top
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import csrc_pkg::*;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic [9:0] ADDR = 10'h000;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic RVALID, PLL_POWER_ON, PD_POLARITY_NEG, SRC_OSC_SEL, PREDIV_BYPASS;
    logic PREDIV_CODE_BAD, OSC_POWER_ON, EXT_TO_PRESCALER;
    logic [1:0] PLL_POWER_MODE;
    logic [2:0] PREDIV_RATIO;
    logic [7:0] ctl;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    assign ctl = {PLL_POWER_ON, PLL_POWER_MODE, PD_POLARITY_NEG, SRC_OSC_SEL, PREDIV_BYPASS,
        OSC_POWER_ON, EXT_TO_PRESCALER};
    csrc_top i_dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
        .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID), .PLL_POWER_ON(PLL_POWER_ON),
        .PLL_POWER_MODE(PLL_POWER_MODE), .PD_POLARITY_NEG(PD_POLARITY_NEG),
        .SRC_OSC_SEL(SRC_OSC_SEL), .PREDIV_BYPASS(PREDIV_BYPASS), .PREDIV_RATIO(PREDIV_RATIO),
        .PREDIV_CODE_BAD(PREDIV_CODE_BAD), .OSC_POWER_ON(OSC_POWER_ON),
        .EXT_TO_PRESCALER(EXT_TO_PRESCALER));
    always #2.5 REF_CLK = ~REF_CLK;
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // A stuck design would otherwise leave the run hanging forever.
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Outputs settle one edge after the write edge, so wait before looking.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        WR_EN = 1'b1; ADDR = a; WDATA = d;
        @(negedge REF_CLK) WR_EN = 1'b0;
        repeat (2) @(negedge REF_CLK);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        RD_EN = 1'b1; ADDR = a;
        @(negedge REF_CLK) RD_EN = 1'b0;
        chk("rvalid", {7'h00, RVALID}, 8'h01);
        chk("rdata", RDATA, e);
        // An idle cycle keeps the strobe from being lowered and raised in one time step.
        @(negedge REF_CLK);
        chk("rvalid", {7'h00, RVALID}, 8'h00);
        chk("rdata", RDATA, e);
    endtask : rd
    task automatic t_defaults();
        chk("ctl", ctl, 8'h20);
        chk("ratio", {5'h00, PREDIV_RATIO}, 8'h04);
        chk("bad", {7'h00, PREDIV_CODE_BAD}, 8'h00);
        rd(CSRC_ADDR_PLL_CONTROL, 8'h01);
        rd(CSRC_ADDR_PREDIV_RATIO, 8'h02);
        rd(CSRC_ADDR_SOURCE_SELECT, 8'h00);
    endtask : t_defaults
    task automatic t_ratio();
        for (int c = 0; c < 8; c++) begin
            wr(CSRC_ADDR_PREDIV_RATIO, {5'h15, 3'(c)});
            chk("ratio", {5'h00, PREDIV_RATIO}, (c <= 4) ? 8'(c + 2) : 8'h02);
            chk("bad", {7'h00, PREDIV_CODE_BAD}, {7'h00, c > 4});
            rd(CSRC_ADDR_PREDIV_RATIO, {5'h15, 3'(c)});
        end
    endtask : t_ratio
    task automatic t_source();
        logic [1:0] s;
        for (int p = 0; p < 2; p++) begin
            wr(CSRC_ADDR_PLL_CONTROL, (p == 1) ? 8'h00 : 8'h01);
            for (int k = 0; k < 4; k++) begin
                s = 2'(k);
                wr(CSRC_ADDR_SOURCE_SELECT, {6'h00, s});
                if (p == 1) chk("ctl", ctl, {3'h4, 1'h0, s, s[1], ~s[1]});
                else chk("ctl", ctl, {3'h1, 1'h0, s, 2'h0});
            end
        end
    endtask : t_source
    task automatic t_polarity();
        wr(CSRC_ADDR_SOURCE_SELECT, 8'h00);
        wr(CSRC_ADDR_PLL_CONTROL, 8'h81);
        chk("ctl", ctl, 8'h30);
        wr(10'h011, 8'hff);
        chk("ctl", ctl, 8'h30);
        rd(10'h011, 8'h00);
        rd(CSRC_ADDR_PLL_CONTROL, 8'h81);
        wr(CSRC_ADDR_PLL_CONTROL, 8'h02);
        chk("ctl", ctl, 8'h40);
        wr(CSRC_ADDR_PLL_CONTROL, 8'h03);
        chk("ctl", ctl, 8'h60);
    endtask : t_polarity
    task automatic t_rerst();
        RSTN = 1'b0;
        @(negedge REF_CLK) RSTN = 1'b1;
        @(negedge REF_CLK);
        t_defaults();
    endtask : t_rerst
    initial begin
        repeat (8) @(negedge REF_CLK);
        RSTN = 1'b1;
        @(negedge REF_CLK);
        t_defaults();
        t_ratio();
        t_source();
        t_polarity();
        t_rerst();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
